// *** hw/ulra_pkg.sv ***
// constants and types for the ulpi register access block
// Function
// - top two bits give command class
// - class 01, low bits zero: no-pid transmit
// - transmit pid sits in low nibble
// - class 10: immediate write, 6-bit address
// - write address 2f: extended, address next
// - class 11: immediate read, 6-bit address
// - read address 2f: extended, address next
// - registers keep contents in special modes
// - commit byte after stp drops, lower nxt
// - dir stays low during register write
// - read: nxt, then dir high, nxt low
// - after turnaround drive data, drop dir
// - extended read: address then turnaround, data
// - no bus reading during turnaround cycles
// - everything on rising edge of interface clock
// - dir high while unable to accept commands
package ulra_pkg;
   localparam logic [1:0] ULRA_CLS_IDLE  = 2'h0;
   localparam logic [1:0] ULRA_CLS_TX    = 2'h1;
   localparam logic [1:0] ULRA_CLS_WRITE = 2'h2;
   localparam logic [1:0] ULRA_CLS_READ  = 2'h3;
   localparam logic [5:0] ULRA_EXT_ADDR  = 6'h2f;
   localparam logic [7:0] ULRA_IDLE_BYTE = 8'h00;
   localparam int         ULRA_REG_NUM   = 256;
   localparam logic [7:0] ULRA_REG_RESET = 8'h00;
   // startup hold of dir: 1 us at 100 ns period, least time rounds up
   localparam int         ULRA_STARTUP_NS  = 1000;
   localparam int         ULRA_CLK_NS      = 100;
   localparam int         ULRA_STARTUP_CYC =
      (ULRA_STARTUP_NS + ULRA_CLK_NS - 1) / ULRA_CLK_NS;

   typedef enum logic [3:0] {
      ULRA_S_BUSY, ULRA_S_IDLE, ULRA_S_TXPKT,
      ULRA_S_WNXT, ULRA_S_WEXT, ULRA_S_WDATA, ULRA_S_WSTP,
      ULRA_S_RNXT, ULRA_S_REXT, ULRA_S_RTURN, ULRA_S_RDATA,
      ULRA_S_RBACK
   } ulra_state_t;

   function automatic logic [1:0] ulra_class(input logic [7:0] cmd);
      return cmd[7:6];
   endfunction

   function automatic logic ulra_is_ext(input logic [7:0] cmd);
      return cmd[5:0] == ULRA_EXT_ADDR;
   endfunction
endpackage

// *** hw/ulra_regfile.sv ***
// register array of the ulpi register access block
`timescale 1ns/100ps
module ulra_regfile (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // read port
   input  wire logic [7:0] rd_addr,
   output      logic [7:0] rd_data
);
   import ulra_pkg::*;

   logic [7:0] mem      [ULRA_REG_NUM];
   logic [7:0] next_mem [ULRA_REG_NUM];

   // no mode input touches the array, so contents survive any mode
   always_comb begin
      for (int i = 0; i < ULRA_REG_NUM; i++) begin
         next_mem[i] = mem[i];
      end
      if (wr_en) begin
         next_mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < ULRA_REG_NUM; i++) begin
            mem[i] <= ULRA_REG_RESET;
         end
      end else begin
         mem <= next_mem;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule

// *** hw/ulra_top.sv ***
// ulpi phy-side command decoder and register access sequencer
`timescale 1ns/100ps
module ulra_top (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // ulpi data bus, split into in, out, enable
   input  wire logic [7:0] data_in,
   output      logic [7:0] data_out,
   output      logic       data_oe,
   // ulpi control
   input  wire logic       stp,
   output      logic       dir,
   output      logic       nxt,
   // transmit path hand-off
   output      logic       tx_start,
   output      logic       tx_has_pid,
   output      logic [3:0] tx_pid
);
   import ulra_pkg::*;

   ulra_state_t state, next_state;
   logic [7:0]  addr, next_addr;
   logic [7:0]  wdata, next_wdata;
   logic [7:0]  dout, next_dout;
   logic        next_dir, next_nxt;
   logic        next_tx_start, next_tx_has_pid;
   logic [3:0]  next_tx_pid;
   logic [3:0]  wait_cnt, next_wait_cnt;
   logic        wr_en;
   logic [7:0]  rd_data;

   ulra_regfile u_regs (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (wr_en),
      .wr_addr (addr),
      .wr_data (wdata),
      .rd_addr (addr),
      .rd_data (rd_data)
   );

   // link logic shares clk, so inputs are not synchronised
   always_comb begin
      next_state      = state;
      next_addr       = addr;
      next_wdata      = wdata;
      next_dout       = dout;
      next_dir        = dir;
      next_nxt        = nxt;
      next_tx_start   = 1'b0;
      next_tx_has_pid = tx_has_pid;
      next_tx_pid     = tx_pid;
      next_wait_cnt   = wait_cnt;
      wr_en           = 1'b0;
      case (state)
         ULRA_S_BUSY: begin
            // dir held high until ready for commands
            next_dir = 1'b1;
            if (wait_cnt == 4'(ULRA_STARTUP_CYC - 1)) begin
               next_dir   = 1'b0;
               next_state = ULRA_S_RBACK;
            end else begin
               next_wait_cnt = wait_cnt + 4'h1;
            end
         end
         ULRA_S_IDLE: begin
            // only look at the bus while dir is low
            if (!dir) begin
               case (ulra_class(data_in))
                  ULRA_CLS_TX: begin
                     if (data_in[5:4] == 2'h0) begin
                        next_tx_start   = 1'b1;
                        next_tx_has_pid = data_in[3:0] != 4'h0;
                        next_tx_pid     = data_in[3:0];
                        next_state      = ULRA_S_TXPKT;
                     end
                  end
                  ULRA_CLS_WRITE: begin
                     next_addr  = {2'h0, data_in[5:0]};
                     next_nxt   = 1'b1;
                     next_state = ulra_is_ext(data_in) ?
                                  ULRA_S_WEXT : ULRA_S_WNXT;
                  end
                  ULRA_CLS_READ: begin
                     next_addr  = {2'h0, data_in[5:0]};
                     next_nxt   = 1'b1;
                     next_state = ulra_is_ext(data_in) ?
                                  ULRA_S_REXT : ULRA_S_RNXT;
                  end
                  default: begin
                     next_state = ULRA_S_IDLE;
                  end
               endcase
            end
         end
         ULRA_S_TXPKT: begin
            // packet datapath lives elsewhere; wait for end of frame
            if (stp) begin
               next_state = ULRA_S_IDLE;
            end
         end
         ULRA_S_WEXT: begin
            // extended address byte follows the command
            next_addr  = data_in;
            next_state = ULRA_S_WNXT;
         end
         ULRA_S_WNXT: begin
            // data byte taken while nxt high, dir stays low
            next_wdata = data_in;
            next_nxt   = 1'b0;
            next_state = ULRA_S_WSTP;
         end
         ULRA_S_WSTP: begin
            // commit once stp has been seen and released
            if (stp) begin
               next_state = ULRA_S_WDATA;
            end
         end
         ULRA_S_WDATA: begin
            if (!stp) begin
               wr_en      = 1'b1;
               next_state = ULRA_S_IDLE;
            end
         end
         ULRA_S_REXT: begin
            next_addr  = data_in;
            next_state = ULRA_S_RNXT;
         end
         ULRA_S_RNXT: begin
            // take the bus and drop nxt together
            next_dir   = 1'b1;
            next_nxt   = 1'b0;
            next_state = ULRA_S_RTURN;
         end
         ULRA_S_RTURN: begin
            // turnaround: drive nothing, then present data
            next_dout  = rd_data;
            next_state = ULRA_S_RDATA;
         end
         ULRA_S_RDATA: begin
            // dout back to idle so data_out stays a plain flip-flop
            next_dout  = ULRA_IDLE_BYTE;
            next_dir   = 1'b0;
            next_state = ULRA_S_RBACK;
         end
         ULRA_S_RBACK: begin
            // bus turnaround back to link, ignore this cycle
            next_state = ULRA_S_IDLE;
         end
         default: begin
            next_state = ULRA_S_BUSY;
         end
      endcase
   end

   // all sampling and updates on the rising edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state      <= ULRA_S_BUSY;
         addr       <= 8'h00;
         wdata      <= 8'h00;
         dout       <= 8'h00;
         dir        <= 1'b1;
         nxt        <= 1'b0;
         tx_start   <= 1'b0;
         tx_has_pid <= 1'b0;
         tx_pid     <= 4'h0;
         wait_cnt   <= 4'h0;
      end else begin
         state      <= next_state;
         addr       <= next_addr;
         wdata      <= next_wdata;
         dout       <= next_dout;
         dir        <= next_dir;
         nxt        <= next_nxt;
         tx_start   <= next_tx_start;
         tx_has_pid <= next_tx_has_pid;
         tx_pid     <= next_tx_pid;
         wait_cnt   <= next_wait_cnt;
      end
   end

   // drive only in the data cycle, never in turnaround
   assign data_oe  = (state == ULRA_S_RDATA);
   assign data_out = dout;

   AST_WRITE_DIR_LOW: assert property (
      @(posedge clk) disable iff (!resetn)
      state inside {ULRA_S_WNXT, ULRA_S_WEXT, ULRA_S_WSTP, ULRA_S_WDATA}
      |-> !dir)
      else $error("dir high during write");
   AST_READ_SEQ: assert property (
      @(posedge clk) disable iff (!resetn)
      (state == ULRA_S_RNXT) |=> dir && !nxt ##1 data_oe ##1 !dir)
      else $error("read sequence wrong");
   AST_TURN_NO_DRIVE: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(dir) |-> !data_oe)
      else $error("drove during turnaround");
   AST_DATA_ONE_CYCLE: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(data_oe) |=> !data_oe && !dir)
      else $error("read data not one cycle");
   AST_CMD_ONLY_DIR_LOW: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(nxt) |-> !$past(dir))
      else $error("command taken with dir high");
   AST_COMMIT_AFTER_STP: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_en |-> !stp && $past(stp))
      else $error("write committed without stp");
   AST_CLASS_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      (state == ULRA_S_IDLE && !dir && data_in[7:6] == ULRA_CLS_WRITE)
      |=> nxt && !dir)
      else $error("write command not acknowledged");
   AST_EXT_ADDR: assert property (
      @(posedge clk) disable iff (!resetn)
      (state == ULRA_S_IDLE && !dir && data_in == 8'hef)
      |=> state == ULRA_S_REXT)
      else $error("extended read not decoded");
   AST_STARTUP_DIR: assert property (
      @(posedge clk) disable iff (!resetn)
      (state == ULRA_S_BUSY) |-> dir)
      else $error("dir low during startup");

   COV_WRITE:  cover property (@(posedge clk) disable iff (!resetn) wr_en);
   COV_READ:   cover property (@(posedge clk) disable iff (!resetn)
      $rose(data_oe));
   COV_EXTRD:  cover property (@(posedge clk) disable iff (!resetn)
      state == ULRA_S_REXT);
   COV_TX:     cover property (@(posedge clk) disable iff (!resetn) tx_start);
endmodule

// *** verif/ulra_link_model.sv ***
// link controller model facing the phy on the ulpi bus
`timescale 1ns/100ps
module ulra_link_model (
   // clock
   input  wire logic       clk,
   // bus and control as the link sees them
   input  wire logic [7:0] bus,
   input  wire logic       dir,
   input  wire logic       nxt,
   // link drive
   output      logic [7:0] ld,
   output      logic       loe,
   output      logic       stp
);
   initial begin
      ld = 8'h00;
      loe = 1'h0;
      stp = 1'h0;
   end

   // raw drive with no handshake, only for reset-time tests
   task automatic put(input logic [7:0] c);
      ld <= c;
      loe <= 1'h1;
   endtask

   // all drive changes just after a rising edge
   task automatic go(input logic [7:0] c);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dir !== 1'h0 && n < 40);
      ld <= c;
      loe <= 1'h1;
   endtask

   // np: bit 7 any dir high, low bits nxt history
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic x, output logic [7:0] np);
      int n;
      n = x ? 2 : 1;
      go({2'h2, x ? 6'h2f : a[5:0]});
      np = 8'h00;
      for (int i = 0; i < n + 3; i++) begin
         @(posedge clk);
         np = {np[7] | dir, np[5:0], nxt};
         // address first when extended
         ld <= (i == 0 && x) ? a : (i < n) ? d : 8'h00;
         stp <= (i == n);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic x,
                     output logic [7:0] v, output logic [7:0] np);
      int k;
      k = 0;
      v = 8'h00;
      go({2'h3, x ? 6'h2f : a[5:0]});
      np = 8'h00;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         np = {np[6:0], nxt};
         k = k + int'(dir);
         if (dir === 1'h1 && k == 2) begin
            v = bus;
         end
         // idle only once the turnaround is over
         loe <= (i == 0 && x) || (dir === 1'h0 && k > 0);
         ld <= (i == 0 && x) ? a : 8'h00;
      end
   endtask

   task automatic tx(input logic [7:0] c);
      go(c);
      @(posedge clk);
      ld <= 8'h00;
      @(posedge clk);
      stp <= 1'h1;
      @(posedge clk);
      stp <= 1'h0;
   endtask
endmodule

// *** verif/testbench.sv ***
// testbench for the ulpi register access block
`timescale 1ns/100ps
module testbench;
   typedef struct {
      logic [1:0] op;
      logic       x;
      logic [7:0] a;
      logic [7:0] d;
   } ulra_row_t;
   // op 0 write, 1 read back, 2 transmit (d: start, pid flag, pid)
   ulra_row_t rows[18] = '{
      '{2'h0, 1'h0, 8'h3f, 8'ha5}, '{2'h0, 1'h1, 8'hf3, 8'h3c},
      '{2'h0, 1'h1, 8'h2f, 8'h81}, '{2'h0, 1'h0, 8'h2e, 8'h7e},
      '{2'h0, 1'h0, 8'h00, 8'h5a}, '{2'h1, 1'h0, 8'h3f, 8'ha5},
      '{2'h1, 1'h1, 8'hf3, 8'h3c}, '{2'h1, 1'h1, 8'h2f, 8'h81},
      '{2'h1, 1'h0, 8'h2e, 8'h7e}, '{2'h1, 1'h0, 8'h00, 8'h5a},
      '{2'h1, 1'h1, 8'hbf, 8'h00}, '{2'h1, 1'h0, 8'h05, 8'h00},
      '{2'h2, 1'h0, 8'h40, 8'h20}, '{2'h2, 1'h0, 8'h41, 8'h31},
      '{2'h2, 1'h0, 8'h4f, 8'h3f}, '{2'h2, 1'h0, 8'h48, 8'h38},
      '{2'h2, 1'h0, 8'h50, 8'h00}, '{2'h2, 1'h0, 8'h00, 8'h00}
   };
   ulra_row_t  r;
   logic       clk;
   logic       resetn;
   logic [7:0] bus;
   logic [7:0] data_out;
   logic [7:0] ld;
   logic [7:0] v;
   logic [7:0] np;
   logic       data_oe;
   logic       stp;
   logic       dir;
   logic       nxt;
   logic       loe;
   logic       tx_start;
   logic       tx_has_pid;
   logic [3:0] tx_pid;
   logic [5:0] seen;
   int         n_tx;
   int         k0;
   int         n_fail;
   int         checks;

   ulra_top dut (.clk(clk), .resetn(resetn), .data_in(bus),
      .data_out(data_out), .data_oe(data_oe), .stp(stp), .dir(dir),
      .nxt(nxt), .tx_start(tx_start), .tx_has_pid(tx_has_pid),
      .tx_pid(tx_pid));
   ulra_link_model lnk (.clk(clk), .bus(bus), .dir(dir), .nxt(nxt),
      .ld(ld), .loe(loe), .stp(stp));

   // undriven bus shows the inverse so stale values cannot pass
   assign bus = data_oe ? data_out : (loe ? ld : ~ld);

   always @(posedge clk) begin
      if (tx_start === 1'h1) begin
         seen <= {1'h1, tx_has_pid, tx_pid};
         n_tx <= n_tx + 1;
      end
   end

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("Error at %0t: saw %h want %h", $time, s, e);
      end
   endtask

   task automatic stop_test;
      $display("n_fail=%0d checks=%0d", n_fail, checks);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   initial begin
      #(3000 * 100);
      n_fail++;
      stop_test;
   end

   initial begin
      resetn = 1'h0;
      n_fail = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      chk({6'h00, dir, nxt}, 8'h02);
      // write command while phy holds the bus must be ignored
      lnk.put(8'h85);
      resetn <= 1'h1;
      repeat (9) @(posedge clk);
      lnk.put(8'h00);
      @(posedge clk);
      chk({7'h00, dir}, 8'h01);
      @(posedge clk);
      chk({6'h00, dir, nxt}, 8'h00);
      @(posedge clk);
      foreach (rows[i]) begin
         r = rows[i];
         case (r.op)
            2'h0: begin
               lnk.wr(r.a, r.d, r.x, np);
               chk(np, r.x ? 8'h0c : 8'h04);
            end
            2'h1: begin
               lnk.rd(r.a, r.x, v, np);
               chk(v, r.d);
               chk(np, r.x ? 8'h60 : 8'h40);
            end
            default: begin
               k0 = n_tx;
               lnk.tx(r.a);
               chk(8'(n_tx - k0), {7'h00, r.d[5]});
               if (r.d[5]) begin
                  chk({2'h0, seen}, {2'h0, r.d[5:0]});
               end
            end
         endcase
      end
      // reset in mid-run: phy takes the bus back, array returns to 00h
      resetn <= 1'h0;
      repeat (2) @(posedge clk);
      chk({6'h00, dir, nxt}, 8'h02);
      resetn <= 1'h1;
      lnk.rd(8'h3f, 1'h0, v, np);
      chk(v, 8'h00);
      chk(np, 8'h40);
      stop_test;
   end
endmodule
